// ==== verilog/itt_timers.sv ====
// Idle timer plus identical PWM / event counter / capture timer blocks with APB registers
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
module itt_timers #(
  parameter int NUM_TIMERS = 3
) (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // Register bus
  input  wire itt_pkg::itt_apb_req_t  apb_req,
  output itt_pkg::itt_apb_rsp_t       apb_rsp,
  // Power control
  input  wire logic                   halt_wakeup,
  output logic                        clocks_held,
  // Timer pins
  input  wire logic [NUM_TIMERS-1:0]  timer_pin_a_in,
  output logic      [NUM_TIMERS-1:0]  timer_pin_a_out,
  output logic      [NUM_TIMERS-1:0]  timer_pin_a_oe_n,
  input  wire logic [NUM_TIMERS-1:0]  timer_pin_b,
  // Interrupt requests
  output logic                        idle_timer_irq,
  output logic      [NUM_TIMERS-1:0]  irq_a,
  output logic      [NUM_TIMERS-1:0]  irq_b
);

  generate
    if (NUM_TIMERS < 1 || NUM_TIMERS > 8) begin : g_bad_num
      $error("NUM_TIMERS must lie between 1 and 8");
    end
  endgenerate

  // One timer block
  typedef struct packed {
    logic                     mode_bit3;
    logic                     mode_bit2;
    logic                     mode_bit1;
    logic                     run_or_underflow_flag;
    logic                     pending_a;
    logic                     irq_enable_a;
    logic                     pending_b;
    logic                     irq_enable_b;
    logic                     reload_from_b;
    logic                     pwm_level;
    logic                     pin_oe_n;
    logic [itt_pkg::TMR_W-1:0] count;
    logic [itt_pkg::TMR_W-1:0] reload_capture_a;
    logic [itt_pkg::TMR_W-1:0] reload_capture_b;
  } itt_tmr_t;

  // Whole module state
  typedef struct packed {
    logic [3:0]                 pre;
    logic [itt_pkg::IDLE_W-1:0] idle_timer;
    logic                       idle_timer_pending;
    logic                       idle_timer_irq_enable;
    logic                       hold;
    logic                       idle_irq;
    logic [NUM_TIMERS-1:0]      irq_a;
    logic [NUM_TIMERS-1:0]      irq_b;
    itt_tmr_t [NUM_TIMERS-1:0]  tmr;
    logic                       pready;
    logic                       pslverr;
    logic [31:0]                prdata;
  } itt_state_t;

  itt_state_t            st_r;
  itt_state_t            st_nxt;

  logic [NUM_TIMERS-1:0] rise_a;
  logic [NUM_TIMERS-1:0] fall_a;
  logic [NUM_TIMERS-1:0] rise_b;
  logic [NUM_TIMERS-1:0] fall_b;
  logic [NUM_TIMERS-1:0] set_pnda;
  logic [NUM_TIMERS-1:0] set_pndb;
  logic [NUM_TIMERS-1:0] set_c0;
  itt_pkg::itt_mode_t    mode [NUM_TIMERS];
  logic                  instruction_cycle_tick;
  logic                  run_tick;
  logic                  idle_set;
  logic                  edge_a;
  logic                  edge_b;
  logic                  setup;
  logic                  access;
  logic                  wr;
  logic                  addr_ok;
  logic                  sel_idle;
  logic                  sel_status;
  logic [NUM_TIMERS-1:0] sel_tmr;
  logic [1:0]            sub;
  logic [31:0]           rdata;
  logic [7:0]            wbyte;

  // Pin synchronisers
  generate
    for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_sync
      itt_pin_sync u_sync_a (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin     (timer_pin_a_in[g]),
        .rise    (rise_a[g]),
        .fall    (fall_a[g])
      );
      itt_pin_sync u_sync_b (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin     (timer_pin_b[g]),
        .rise    (rise_b[g]),
        .fall    (fall_b[g])
      );
    end
  endgenerate

  // Mode decode
  always_comb begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (st_r.tmr[i].mode_bit2) begin
        mode[i] = itt_pkg::ITT_CAPT;
      end else if (st_r.tmr[i].mode_bit3) begin
        mode[i] = itt_pkg::ITT_PWM;
      end else begin
        mode[i] = itt_pkg::ITT_EVENT;
      end
    end
  end

  always_comb begin
    st_nxt   = st_r;
    set_pnda = '0;
    set_pndb = '0;
    set_c0   = '0;
    edge_a   = 1'b0;
    edge_b   = 1'b0;
    idle_set = 1'b0;

    // Instruction cycle prescaler
    instruction_cycle_tick = (st_r.pre == itt_pkg::TICK_DIV - 4'h1);
    st_nxt.pre = instruction_cycle_tick ? itt_pkg::PRE_RST : st_r.pre + 4'h1;
    run_tick = instruction_cycle_tick & ~st_r.hold;

    // Idle timer, never stopped
    if (instruction_cycle_tick) begin
      st_nxt.idle_timer = st_r.idle_timer - 16'h0001;
      idle_set = st_nxt.idle_timer[itt_pkg::IDLE_TOGGLE_BIT]
                 != st_r.idle_timer[itt_pkg::IDLE_TOGGLE_BIT];
      if (st_r.hold && st_r.idle_timer == 16'h0000) begin
        st_nxt.hold = 1'b0;
      end
    end
    if (halt_wakeup) begin
      st_nxt.idle_timer = itt_pkg::IDLE_WAKE_LOAD;
      st_nxt.hold = 1'b1;
      idle_set = 1'b0;
    end

    // Timer blocks
    for (int i = 0; i < NUM_TIMERS; i++) begin
      unique case (mode[i])
        itt_pkg::ITT_PWM: begin
          if (st_r.tmr[i].run_or_underflow_flag && run_tick) begin
            if (st_r.tmr[i].count == 16'h0000) begin
              if (st_r.tmr[i].reload_from_b) begin
                st_nxt.tmr[i].count = st_r.tmr[i].reload_capture_b;
                set_pndb[i] = 1'b1;
              end else begin
                st_nxt.tmr[i].count = st_r.tmr[i].reload_capture_a;
                set_pnda[i] = 1'b1;
              end
              st_nxt.tmr[i].reload_from_b = ~st_r.tmr[i].reload_from_b;
              if (st_r.tmr[i].mode_bit1) begin
                st_nxt.tmr[i].pwm_level = ~st_r.tmr[i].pwm_level;
              end
            end else begin
              st_nxt.tmr[i].count = st_r.tmr[i].count - 16'h0001;
            end
          end
        end
        itt_pkg::ITT_EVENT: begin
          edge_a = st_r.tmr[i].mode_bit1 ? fall_a[i] : rise_a[i];
          if (st_r.tmr[i].run_or_underflow_flag && edge_a && !st_r.hold) begin
            if (st_r.tmr[i].count == 16'h0000) begin
              st_nxt.tmr[i].count = st_r.tmr[i].reload_capture_a;
              set_pnda[i] = 1'b1;
            end else begin
              st_nxt.tmr[i].count = st_r.tmr[i].count - 16'h0001;
            end
          end
          if (rise_b[i] && !st_r.hold) begin
            set_pndb[i] = 1'b1;
          end
        end
        itt_pkg::ITT_CAPT: begin
          if (run_tick) begin
            st_nxt.tmr[i].count = st_r.tmr[i].count - 16'h0001;
            if (st_r.tmr[i].count == 16'h0000) begin
              set_c0[i] = 1'b1;
            end
          end
          edge_a = st_r.tmr[i].mode_bit1 ? fall_a[i] : rise_a[i];
          edge_b = st_r.tmr[i].mode_bit3 ? fall_b[i] : rise_b[i];
          if (edge_a && !st_r.hold) begin
            st_nxt.tmr[i].reload_capture_a = st_r.tmr[i].count;
            set_pnda[i] = 1'b1;
          end
          if (edge_b && !st_r.hold) begin
            st_nxt.tmr[i].reload_capture_b = st_r.tmr[i].count;
            set_pndb[i] = 1'b1;
          end
        end
      endcase
      st_nxt.tmr[i].pin_oe_n = (mode[i] != itt_pkg::ITT_PWM);
    end

    // APB decode
    setup    = apb_req.psel & ~apb_req.penable;
    access   = apb_req.psel & apb_req.penable & st_r.pready;
    sub      = apb_req.paddr[3:2];
    sel_idle   = (apb_req.paddr == itt_pkg::IDLE_CTRL_OFS);
    sel_status = (apb_req.paddr == itt_pkg::STATUS_OFS);
    for (int i = 0; i < NUM_TIMERS; i++) begin
      sel_tmr[i] = (apb_req.paddr[7:4] == itt_pkg::TMR_BASE_IDX + 4'(i))
                   && (apb_req.paddr[1:0] == 2'b00);
    end
    addr_ok = sel_idle | sel_status | (|sel_tmr);
    wr      = access & apb_req.pwrite & addr_ok;
    wbyte   = apb_req.pwdata[7:0];

    // Read data; the idle count itself is never visible
    rdata = 32'h0000_0000;
    if (sel_idle) begin
      rdata[itt_pkg::IDLE_EN_BIT]  = st_r.idle_timer_irq_enable;
      rdata[itt_pkg::IDLE_PND_BIT] = st_r.idle_timer_pending;
    end
    if (sel_status) begin
      rdata[itt_pkg::ST_IDLE_IRQ] = st_r.idle_irq;
      rdata[itt_pkg::ST_HOLD]     = st_r.hold;
      for (int i = 0; i < NUM_TIMERS; i++) begin
        rdata[itt_pkg::ST_IRQA_BASE + i] = st_r.irq_a[i];
        rdata[itt_pkg::ST_IRQB_BASE + i] = st_r.irq_b[i];
      end
    end
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (sel_tmr[i]) begin
        unique case (sub)
          itt_pkg::TMR_CTRL_SUB: begin
            rdata[7:0] = {st_r.tmr[i].mode_bit3, st_r.tmr[i].mode_bit2,
                          st_r.tmr[i].mode_bit1, st_r.tmr[i].run_or_underflow_flag,
                          st_r.tmr[i].pending_a, st_r.tmr[i].irq_enable_a,
                          st_r.tmr[i].pending_b, st_r.tmr[i].irq_enable_b};
          end
          itt_pkg::TMR_CNT_SUB: rdata[15:0] = st_r.tmr[i].count;
          itt_pkg::TMR_RA_SUB:  rdata[15:0] = st_r.tmr[i].reload_capture_a;
          itt_pkg::TMR_RB_SUB:  rdata[15:0] = st_r.tmr[i].reload_capture_b;
        endcase
      end
    end

    // APB response, one wait-free access phase
    st_nxt.pready = setup;
    if (setup) begin
      st_nxt.pslverr = ~addr_ok;
      st_nxt.prdata  = apb_req.pwrite ? 32'h0000_0000 : rdata;
    end

    // APB writes
    if (wr && sel_idle) begin
      st_nxt.idle_timer_irq_enable = apb_req.pwdata[itt_pkg::IDLE_EN_BIT];
      st_nxt.idle_timer_pending    = apb_req.pwdata[itt_pkg::IDLE_PND_BIT];
    end
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (wr && sel_tmr[i]) begin
        unique case (sub)
          itt_pkg::TMR_CTRL_SUB: begin
            st_nxt.tmr[i].mode_bit3             = wbyte[itt_pkg::C3_BIT];
            st_nxt.tmr[i].mode_bit2             = wbyte[itt_pkg::C2_BIT];
            st_nxt.tmr[i].mode_bit1             = wbyte[itt_pkg::C1_BIT];
            st_nxt.tmr[i].run_or_underflow_flag = wbyte[itt_pkg::C0_BIT];
            st_nxt.tmr[i].pending_a             = wbyte[itt_pkg::PNDA_BIT];
            st_nxt.tmr[i].irq_enable_a          = wbyte[itt_pkg::ENA_BIT];
            st_nxt.tmr[i].pending_b             = wbyte[itt_pkg::PNDB_BIT];
            st_nxt.tmr[i].irq_enable_b          = wbyte[itt_pkg::ENB_BIT];
            st_nxt.tmr[i].reload_from_b         = 1'b0;
          end
          itt_pkg::TMR_CNT_SUB: st_nxt.tmr[i].count = apb_req.pwdata[15:0];
          itt_pkg::TMR_RA_SUB:  st_nxt.tmr[i].reload_capture_a = apb_req.pwdata[15:0];
          itt_pkg::TMR_RB_SUB:  st_nxt.tmr[i].reload_capture_b = apb_req.pwdata[15:0];
        endcase
      end
    end

    // Hardware sets win over software clears
    if (idle_set) begin
      st_nxt.idle_timer_pending = 1'b1;
    end
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (set_pnda[i]) begin
        st_nxt.tmr[i].pending_a = 1'b1;
      end
      if (set_pndb[i]) begin
        st_nxt.tmr[i].pending_b = 1'b1;
      end
      if (set_c0[i]) begin
        st_nxt.tmr[i].run_or_underflow_flag = 1'b1;
      end
    end

    // Interrupt request lines
    st_nxt.idle_irq = st_nxt.idle_timer_pending & st_nxt.idle_timer_irq_enable;
    for (int i = 0; i < NUM_TIMERS; i++) begin
      st_nxt.irq_a[i] = (st_nxt.tmr[i].pending_a
                         | (st_nxt.tmr[i].mode_bit2 & st_nxt.tmr[i].run_or_underflow_flag))
                        & st_nxt.tmr[i].irq_enable_a;
      st_nxt.irq_b[i] = st_nxt.tmr[i].pending_b & st_nxt.tmr[i].irq_enable_b;
    end

    // Synchronous reset of control state and prescaler only; idle and timer counts keep their contents
    if (rst) begin
      st_nxt.pre                   = itt_pkg::PRE_RST;
      st_nxt.idle_timer_pending    = 1'b0;
      st_nxt.idle_timer_irq_enable = 1'b0;
      st_nxt.hold                  = 1'b0;
      st_nxt.idle_irq              = 1'b0;
      st_nxt.irq_a                 = '0;
      st_nxt.irq_b                 = '0;
      st_nxt.pready                = 1'b0;
      st_nxt.pslverr               = 1'b0;
      st_nxt.prdata                = 32'h0000_0000;
      for (int i = 0; i < NUM_TIMERS; i++) begin
        {st_nxt.tmr[i].mode_bit3, st_nxt.tmr[i].mode_bit2,
         st_nxt.tmr[i].mode_bit1, st_nxt.tmr[i].run_or_underflow_flag,
         st_nxt.tmr[i].pending_a, st_nxt.tmr[i].irq_enable_a,
         st_nxt.tmr[i].pending_b, st_nxt.tmr[i].irq_enable_b} = itt_pkg::CTRL_RST;
        st_nxt.tmr[i].reload_from_b = 1'b0;
        st_nxt.tmr[i].pwm_level     = 1'b0;
        st_nxt.tmr[i].pin_oe_n      = 1'b1;
      end
      // Idle count, timer counts and A/B registers left untouched
    end
  end

  always_ff @(posedge ref_clk) begin
    st_r <= st_nxt;
  end

  // Outputs straight from the state register
  assign apb_rsp.pready  = st_r.pready;
  assign apb_rsp.pslverr = st_r.pslverr;
  assign apb_rsp.prdata  = st_r.prdata;
  assign clocks_held     = st_r.hold;
  assign idle_timer_irq  = st_r.idle_irq;
  assign irq_a           = st_r.irq_a;
  assign irq_b           = st_r.irq_b;

  always_comb begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      timer_pin_a_out[i]  = st_r.tmr[i].pwm_level;
      timer_pin_a_oe_n[i] = st_r.tmr[i].pin_oe_n;
    end
  end

endmodule

// ==== common/itt_pkg.sv ====
// Shared constants, bus carriers and mode codes of the timer subsystem
package itt_pkg;

  // Counter widths
  localparam int TMR_W           = 16;
  localparam int IDLE_W          = 16;
  localparam int IDLE_TOGGLE_BIT = 12;

  // Instruction cycle prescaler: oscillator divided by ten
  localparam logic [3:0]  TICK_DIV       = 4'hA;
  localparam logic [15:0] IDLE_WAKE_LOAD = 16'h0100;

  // Register offsets (byte addresses)
  localparam logic [7:0] IDLE_CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS    = 8'h04;
  localparam logic [3:0] TMR_BASE_IDX  = 4'h1;
  localparam logic [1:0] TMR_CTRL_SUB  = 2'h0;
  localparam logic [1:0] TMR_CNT_SUB   = 2'h1;
  localparam logic [1:0] TMR_RA_SUB    = 2'h2;
  localparam logic [1:0] TMR_RB_SUB    = 2'h3;

  // Timer control byte fields
  localparam int C3_BIT   = 7;
  localparam int C2_BIT   = 6;
  localparam int C1_BIT   = 5;
  localparam int C0_BIT   = 4;
  localparam int PNDA_BIT = 3;
  localparam int ENA_BIT  = 2;
  localparam int PNDB_BIT = 1;
  localparam int ENB_BIT  = 0;

  // Idle control and status fields
  localparam int IDLE_EN_BIT   = 0;
  localparam int IDLE_PND_BIT  = 1;
  localparam int ST_IDLE_IRQ   = 0;
  localparam int ST_HOLD       = 1;
  localparam int ST_IRQA_BASE  = 8;
  localparam int ST_IRQB_BASE  = 16;

  // Values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] PRE_RST  = 4'h0;

  // Timer block operating modes
  typedef enum logic [2:0] {
    ITT_EVENT = 3'b001,
    ITT_PWM   = 3'b010,
    ITT_CAPT  = 3'b100
  } itt_mode_t;

  // APB request and response
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } itt_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } itt_apb_rsp_t;

endpackage

// ==== verilog/itt_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module itt_pin_sync (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Pin side
  input  wire logic pin,
  // Filtered edges
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic [2:0] stage;
    logic       lvl;
  } itt_sync_st_t;

  itt_sync_st_t st_r;
  itt_sync_st_t st_nxt;
  logic         chg;

  always_comb begin
    st_nxt = st_r;
    st_nxt.stage = {st_r.stage[1:0], pin};
    chg = (st_r.stage[2] == st_r.stage[1]) && (st_r.stage[2] != st_r.lvl);
    if (chg) begin
      st_nxt.lvl = st_r.stage[2];
    end
    if (rst) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    st_r <= st_nxt;
  end

  assign rise = chg & st_r.stage[2];
  assign fall = chg & ~st_r.stage[2];

endmodule

// ==== dv/itt_pin_model.sv ====
// Pulse sources and PWM load on the timer pins
`timescale 1ns/1ps
module itt_pin_model #(
  parameter int N = 3
) (
  // Source levels
  input  wire logic [N-1:0] lvl_a,
  input  wire logic [N-1:0] lvl_b,
  // Design pin side
  input  wire logic [N-1:0] a_out,
  input  wire logic [N-1:0] a_oe_n,
  output logic      [N-1:0] a_in,
  output logic      [N-1:0] b_in
);
  // Pin A carries the design level while driven, else the source
  assign a_in = (~a_oe_n & a_out) | (a_oe_n & lvl_a);
  assign b_in = lvl_b;
endmodule

// ==== dv/itt_timers_chk.sv ====
// Port checker of the timer subsystem
`timescale 1ns/1ps
module itt_timers_chk #(
  parameter int NUM_TIMERS = 3
) (
  // Clock, reset, bus
  input wire logic                  ref_clk,
  input wire logic                  rst,
  input wire itt_pkg::itt_apb_req_t apb_req,
  input wire itt_pkg::itt_apb_rsp_t apb_rsp,
  // Power control
  input wire logic                  halt_wakeup,
  input wire logic                  clocks_held,
  // Pins and interrupts
  input wire logic [NUM_TIMERS-1:0] timer_pin_a_out,
  input wire logic [NUM_TIMERS-1:0] timer_pin_a_oe_n,
  input wire logic                  idle_timer_irq,
  input wire logic [NUM_TIMERS-1:0] irq_a,
  input wire logic [NUM_TIMERS-1:0] irq_b
);
  logic            wr;
  logic [1:0][7:0] ctl_r;
  logic            ien_r;
  logic [15:0]     held_r;
  assign wr = apb_req.psel & apb_req.penable & apb_rsp.pready & apb_req.pwrite;
  // Written control values and hold length
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctl_r  <= '0;
      ien_r  <= 1'b0;
      held_r <= '0;
    end else begin
      if (wr && apb_req.paddr == 8'h10) ctl_r[0] <= apb_req.pwdata[7:0];
      if (wr && apb_req.paddr == 8'h20) ctl_r[1] <= apb_req.pwdata[7:0];
      if (wr && apb_req.paddr == 8'h00) ien_r <= apb_req.pwdata[0];
      held_r <= clocks_held ? held_r + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_bus_ready: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("pready missing after setup");
  a_bus_refuse: assert property (apb_req.psel && !apb_req.penable && apb_req.paddr == 8'h08
    |=> apb_rsp.pslverr) else $error("unmapped access not refused");
  a_idle_gate: assert property (idle_timer_irq |-> ien_r)
    else $error("idle irq while disabled");
  a_idle_keep: assert property ($past(!rst) && $fell(idle_timer_irq)
    |-> $past(wr && apb_req.paddr == 8'h00)) else $error("idle irq dropped alone");
  a_irq_a_gate: assert property (irq_a[0] |-> ctl_r[0][2])
    else $error("irq a while disabled");
  a_irq_b_keep: assert property ($past(!rst) && $fell(irq_b[1])
    |-> $past(wr && apb_req.paddr == 8'h20)) else $error("irq b dropped alone");
  a_event_hiz: assert property (ctl_r[1][7:6] == 2'b00 && $past(ctl_r[1][7:6]) == 2'b00
    |-> timer_pin_a_oe_n[1]) else $error("event pin driven");
  a_pwm_drive: assert property (ctl_r[0][7:6] == 2'b10 && $past(ctl_r[0][7:6]) == 2'b10
    |-> !timer_pin_a_oe_n[0]) else $error("pwm pin not driven");
  a_pwm_steady: assert property (ctl_r[0][7:5] == 3'b100 && $past(ctl_r[0][7:5]) == 3'b100
    |-> $stable(timer_pin_a_out[0])) else $error("pwm pin moved without toggle");
  a_hold_start: assert property (halt_wakeup |=> clocks_held)
    else $error("hold not started");
  a_hold_len: assert property ($past(!rst) && $fell(clocks_held)
    |-> held_r >= 16'h0A00 && held_r <= 16'h0A0C) else $error("hold length wrong");
  c_idle_evt: cover property ($rose(idle_timer_irq));
  c_pwm_b: cover property ($rose(irq_b[0]));
  c_hold_end: cover property ($fell(clocks_held));
endmodule

bind itt_timers itt_timers_chk #(.NUM_TIMERS(NUM_TIMERS)) i_itt_timers_chk (
  .ref_clk(ref_clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .halt_wakeup(halt_wakeup), .clocks_held(clocks_held), .timer_pin_a_out(timer_pin_a_out),
  .timer_pin_a_oe_n(timer_pin_a_oe_n), .idle_timer_irq(idle_timer_irq), .irq_a(irq_a),
  .irq_b(irq_b));

// ==== dv/test_idle_and_triple_timer_blocks.sv ====
// Self-checking bench of the idle timer and the timer blocks
`timescale 1ns/1ps
module test_idle_and_triple_timer_blocks;
  logic                  ref_clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  halt = 1'b0;
  itt_pkg::itt_apb_req_t req = '0;
  itt_pkg::itt_apb_rsp_t rsp;
  logic [2:0]            lvl_a = '0;
  logic [2:0]            lvl_b = '0;
  logic [2:0]            pa_in, pa_out, pa_oe_n, pb_in, irq_a, irq_b;
  logic                  held, idle_irq, e;
  logic [31:0]           q, q2;
  logic [15:0]           ra, rb;
  int                    failures = 0, checked = 0, seed = 54433, cyc = 0, t1, k;

  always #10 ref_clk = ~ref_clk;

  itt_timers #(.NUM_TIMERS(3)) i_itt_timers (.ref_clk(ref_clk), .rst(rst), .apb_req(req),
    .apb_rsp(rsp), .halt_wakeup(halt), .clocks_held(held), .timer_pin_a_in(pa_in),
    .timer_pin_a_out(pa_out), .timer_pin_a_oe_n(pa_oe_n), .timer_pin_b(pb_in),
    .idle_timer_irq(idle_irq), .irq_a(irq_a), .irq_b(irq_b));
  itt_pin_model #(.N(3)) i_itt_pin_model (.lvl_a(lvl_a), .lvl_b(lvl_b), .a_out(pa_out),
    .a_oe_n(pa_oe_n), .a_in(pa_in), .b_in(pb_in));

  task automatic close_out();
    if (failures == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Cycles from one load of r to the underflow after it
  function automatic int span(input logic [15:0] r);
    return (int'(r) + 1) * int'(itt_pkg::TICK_DIV);
  endfunction

  // One APB transfer, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do @(posedge ref_clk); while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
    @(posedge ref_clk);
  endtask

  // Wait for an event: 0 idle irq, 1 hold over, 2+i irq a, 5+i irq b
  task automatic wt(input int s);
    logic [7:0] v;
    v = {irq_b, irq_a, ~held, idle_irq};
    while (v[s] !== 1'b1) begin
      @(posedge ref_clk);
      v = {irq_b, irq_a, ~held, idle_irq};
    end
  endtask

  task automatic pulse(input int p);
    {lvl_b, lvl_a} <= 6'h01 << p;
    repeat (8) @(posedge ref_clk);
    {lvl_b, lvl_a} <= '0;
    repeat (8) @(posedge ref_clk);
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    cmp("oe_n_rst", 3'h7, pa_oe_n);
    apb(1'b0, 8'h08, '0);
    cmp("err_unmapped", 1, e);
    apb(1'b1, 8'h02, 32'hFFFF);
    cmp("err_misaligned", 1, e);
    // Wakeup hold, then idle events
    halt <= 1'b1;
    @(posedge ref_clk);
    halt <= 1'b0;
    t1 = cyc;
    apb(1'b1, itt_pkg::IDLE_CTRL_OFS, 32'h1);
    apb(1'b0, itt_pkg::STATUS_OFS, '0);
    cmp("status_hold", 1, q[itt_pkg::ST_HOLD]);
    wt(1);
    cmp("hold_len", 1, cyc - t1 >= 2560 && cyc - t1 <= 2572);
    wt(0);
    t1 = cyc;
    apb(1'b1, itt_pkg::IDLE_CTRL_OFS, 32'h1);
    cmp("idle_clear", 0, idle_irq);
    wt(0);
    cmp("idle_period", span(16'h0FFF), cyc - t1);
    apb(1'b1, itt_pkg::IDLE_CTRL_OFS, 32'h2);
    cmp("idle_masked", 0, idle_irq);
    apb(1'b1, itt_pkg::IDLE_CTRL_OFS, 32'h3);
    cmp("idle_unmasked", 1, idle_irq);
    // PWM on timer 0
    ra = 16'(3 + $unsigned($random(seed)) % 8);
    rb = 16'(3 + $unsigned($random(seed)) % 8);
    apb(1'b1, 8'h18, {16'h0000, ra});
    apb(1'b1, 8'h1C, {16'h0000, rb});
    apb(1'b0, 8'h18, '0);
    cmp("ra_back", ra, q);
    apb(1'b1, 8'h14, '0);
    apb(1'b1, 8'h10, 32'hB5);
    @(posedge ref_clk);
    cmp("pwm_drive", 0, pa_oe_n[0]);
    wt(2);
    t1 = cyc;
    cmp("pwm_pin_a", 1, pa_out[0]);
    cmp("pwm_b_first", 0, irq_b[0]);
    wt(5);
    cmp("pwm_a_len", span(ra), cyc - t1);
    cmp("pwm_pin_b", 0, pa_out[0]);
    apb(1'b1, 8'h10, 32'h80);
    apb(1'b0, 8'h14, '0);
    q2 = q;
    repeat (40) @(posedge ref_clk);
    apb(1'b0, 8'h14, '0);
    cmp("pwm_frozen", q2, q);
    // Mid-run reset keeps the reload registers
    rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, 8'h18, '0);
    cmp("ra_kept", ra, q);
    // Event counting on timer 1, rising then falling
    for (k = 0; k < 2; k++) begin
      ra = 16'(1 + $unsigned($random(seed)) % 4);
      apb(1'b1, 8'h28, {16'h0000, ra});
      apb(1'b1, 8'h24, {16'h0000, ra});
      apb(1'b1, 8'h20, k ? 32'h35 : 32'h15);
      repeat (ra) pulse(1);
      cmp("evt_early", 0, irq_a[1]);
      lvl_a[1] <= 1'b1;
      repeat (8) @(posedge ref_clk);
      cmp("evt_sense", k == 0, irq_a[1]);
      lvl_a[1] <= 1'b0;
      repeat (8) @(posedge ref_clk);
      cmp("evt_uflow", 1, irq_a[1]);
      cmp("evt_hiz", 1, pa_oe_n[1]);
      pulse(4);
      cmp("evt_pin_b", 1, irq_b[1]);
    end
    // Capture on timer 2
    apb(1'b1, 8'h34, 32'h8000);
    apb(1'b1, 8'h30, 32'hC5);
    apb(1'b0, 8'h34, '0);
    q2 = q;
    pulse(2);
    apb(1'b0, 8'h38, '0);
    cmp("cap_a", 1, 16'(q2[15:0] - q[15:0]) <= 16'h0003);
    cmp("cap_irq_a", 1, irq_a[2]);
    lvl_b[2] <= 1'b1;
    repeat (8) @(posedge ref_clk);
    cmp("cap_b_rise", 0, irq_b[2]);
    lvl_b[2] <= 1'b0;
    repeat (8) @(posedge ref_clk);
    cmp("cap_b_fall", 1, irq_b[2]);
    apb(1'b1, 8'h30, 32'h44);
    apb(1'b1, 8'h34, 32'h1);
    repeat (30) @(posedge ref_clk);
    cmp("cap_uflow_irq", 1, irq_a[2]);
    apb(1'b0, 8'h30, '0);
    cmp("cap_uflow_flag", 2'b10, q[4:3]);
    apb(1'b1, 8'h30, 32'h64);
    lvl_a[2] <= 1'b1;
    repeat (8) @(posedge ref_clk);
    cmp("cap_a_rise", 0, irq_a[2]);
    lvl_a[2] <= 1'b0;
    repeat (8) @(posedge ref_clk);
    cmp("cap_a_fall", 1, irq_a[2]);
    close_out();
  end
endmodule
